// File: hw/spad_pkg.sv
// Functional notes
// RULE1: Addresses 0x0 to 0xFFFF select boot ROM in every map width.
// RULE2: Boot ROM answers at 0x0 and, with high vectors, at 0xFFFF0000.
// RULE3: Boot ROM mapping is fixed; never aliases or switches to RAM.
// RULE4: Boot ROM takes one 64KB window; partial fill and repeats allowed.
// RULE5: 0x10000 to 0x3FFFFFFF decodes per 64KB page to one target kind.
// RULE6: Static I/O pages are each selectable on their own.
// RULE7: Each peripheral owns one or more whole 64KB pages.
// RULE8: On-chip RAM never aliases; unpopulated RAM space gives bus error.
// RULE9: 0x40000000 to 0x7FFFFFFF selects mapped I/O.
// RULE10: 0x80000000 to 0xFFFFFFFF is one 2GB DRAM window; code keeps page 0xFFFF0000 as boot ROM.
// RULE11: Integrators fill the low 2GB DRAM before higher DRAM.
// RULE12: 36-bit map 0x1_0000_0000 to 0x3_FFFF_FFFF is reserved, empty.
// RULE13: 36-bit map 0x4_0000_0000 to 0x7_FFFF_FFFF is mapped I/O.
// RULE14: 36-bit 2GB at 0x8_0000_0000 is hole or DRAM; above is DRAM.
// RULE15: 40-bit map reserved then mapped I/O at 0x40_0000_0000.
// RULE16: 40-bit range at 0x80_0000_0000 hole or DRAM; DRAM above.
// RULE17: 44-bit map reserved, mapped I/O, hole or DRAM, then DRAM.
// RULE18: 48-bit map reserved, mapped I/O, hole or DRAM, then DRAM.
// RULE19: Each wider map decodes narrower maps identically at low addresses.
// RULE20: Cacheable memory decodes in one security space only; code decodes RAM and DRAM for secure and nonsecure access alike.
// RULE21: Device targets may be dual mapped; security checked by target.
// RULE22: Nonsecure access to secure register reads zero, drops write, no error.
// RULE23: Empty regions never alias; they give a recoverable bus error.
// RULE24: Hole-split DRAM internal address subtracts a fixed high offset.
// RULE25: Unpopulated DRAM partitions never alias and give bus error.
// RULE26: Map width and hole choice are parameters; one-hot selects out.
package spad_pkg;

    // ------------------------------------------------------------
    // Targets
    // ------------------------------------------------------------
    localparam int TGT_W      = 7;
    localparam int TGT_ROM    = 0;
    localparam int TGT_RAM    = 1;
    localparam int TGT_PERI   = 2;
    localparam int TGT_SMEM   = 3;
    localparam int TGT_MIO    = 4;
    localparam int TGT_DRAM   = 5;
    localparam int TGT_ERR    = 6;

    localparam int AW_MAX     = 48;
    localparam int PAGE_SHIFT = 16;
    localparam int PAGE_W     = 14;

    // Low 4GB layout
    localparam logic [47:0] ROM_BASE   = 48'h0000_0000_0000;
    localparam logic [47:0] HIVEC_BASE = 48'h0000_FFFF_0000;
    localparam logic [47:0] SIO_TOP    = 48'h0000_3FFF_FFFF;
    localparam logic [47:0] MIO32_BASE = 48'h0000_4000_0000;
    localparam logic [47:0] DRAM32_BASE = 48'h0000_8000_0000;
    localparam logic [47:0] DRAM32_TOP = 48'h0000_FFFF_FFFF;

    // Page kind codes
    localparam logic [2:0] PK_EMPTY = 3'h0;
    localparam logic [2:0] PK_RAM   = 3'h1;
    localparam logic [2:0] PK_PERI  = 3'h2;
    localparam logic [2:0] PK_SMEM  = 3'h3;
    localparam logic [2:0] PK_MIO   = 3'h4;
    localparam logic [2:0] PK_ROM   = 3'h5;

    typedef struct packed {
        logic [47:0] addr;
        logic        nonsecure_attribute;
        logic        write;
        logic        valid;
    } spad_req_t;

    typedef struct packed {
        logic [TGT_W-1:0] sel;
        logic [47:0]      local_addr;
        logic [PAGE_W-1:0] page;
        logic             write_ignore_read_zero;
        logic             valid;
    } spad_rsp_t;

endpackage

// File: hw/spad_decoder.sv
`timescale 1ns/10ps
module spad_decoder #(
    parameter int          MAP_W       = 48,
    parameter bit          HOLE_EN     = 1'b1,
    parameter int          RAM_BYTES   = 32768,
    parameter int          RAM_PAGE    = 1,
    parameter int          PERI_FIRST  = 16,
    parameter int          PERI_LAST   = 255,
    parameter int          SMEM_FIRST  = 256,
    parameter int          SMEM_LAST   = 511,
    parameter int          SEC_PERI    = 16
) (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire spad_pkg::spad_req_t req,
    output spad_pkg::spad_rsp_t     rsp
);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam bit MAP_W_OK = (MAP_W == 32) || (MAP_W == 36) || (MAP_W == 40)
                              || (MAP_W == 44) || (MAP_W == 48);

    // Refused at elaboration: the page lookup cannot serve these layouts
    if (!MAP_W_OK) begin : g_bad_width
        $error("Unsupported map width");
    end
    if (RAM_BYTES < 1 || RAM_BYTES > 65536) begin : g_bad_ram_size
        $error("On-chip RAM larger than one page");
    end
    if (RAM_PAGE < 1 || RAM_PAGE >= PERI_FIRST) begin : g_bad_ram_page
        $error("Bad on-chip RAM placement");
    end
    if (PERI_FIRST > PERI_LAST || PERI_LAST >= SMEM_FIRST) begin : g_bad_peri
        $error("Bad peripheral page range");
    end
    // Static pages must stay below mapped I/O
    if (SMEM_FIRST > SMEM_LAST || SMEM_LAST > 16383) begin : g_bad_smem
        $error("Bad static memory page range");
    end
    if (SEC_PERI < PERI_FIRST || SEC_PERI > PERI_LAST) begin : g_bad_secure
        $error("Secure page outside peripherals");
    end

    // ------------------------------------------------------------
    // Combinational decode
    // ------------------------------------------------------------
    logic [47:0]                 a;
    logic [15:0]                 up;
    logic [3:0]                  nib;
    int                          lvl;
    logic [spad_pkg::TGT_W-1:0]  sel;
    logic [47:0]                 loc;
    logic [2:0]                  pk;
    logic [15:0]                 pg;
    logic                        wirz;
    spad_pkg::spad_rsp_t         rsp_d;
    spad_pkg::spad_rsp_t         rsp_q;

    // Page kind lookup; each page is one kind only
    function automatic logic [2:0] page_kind(input logic [15:0] p);
        if (p == 16'h0000)
            return spad_pkg::PK_ROM;
        if (p == 16'(RAM_PAGE))
            return spad_pkg::PK_RAM;
        if (p >= 16'(PERI_FIRST) && p <= 16'(PERI_LAST))
            return spad_pkg::PK_PERI;
        if (p >= 16'(SMEM_FIRST) && p <= 16'(SMEM_LAST))
            return spad_pkg::PK_SMEM;
        if (p == spad_pkg::HIVEC_BASE[31:16])
            return spad_pkg::PK_ROM; // RULE2
        if (p >= 16'h4000 && p <= 16'h7FFF)
            return spad_pkg::PK_MIO;
        return spad_pkg::PK_EMPTY;
    endfunction

    always_comb begin
        a     = req.addr;
        sel   = '0;
        loc   = a;
        pk    = spad_pkg::PK_EMPTY;
        pg    = a[31:16];
        wirz  = 1'b0;
        nib   = 4'h0;
        lvl   = 0;
        up    = a[47:32];
        // Beyond supported width: empty, no wrap-around alias
        if ((MAP_W < 48) && ((a >> MAP_W) != 48'h0)) begin
            sel[spad_pkg::TGT_ERR] = 1'b1; // RULE23
        end else if (up == 16'h0) begin
            // 32-bit map, identical inside every wider map
            // Top page stays boot ROM for high vectors, so low DRAM ends one page short
            if (a[31] == 1'b1 && pg != spad_pkg::HIVEC_BASE[31:16]) begin
                sel[spad_pkg::TGT_DRAM] = 1'b1; // RULE10 RULE19
                loc = a - spad_pkg::DRAM32_BASE; // RULE24
            end else begin
                pk = page_kind(pg);
                unique case (pk)
                    spad_pkg::PK_ROM: begin
                        sel[spad_pkg::TGT_ROM] = 1'b1; // RULE1 RULE3 RULE4
                        loc = {32'h0, a[15:0]};
                    end
                    spad_pkg::PK_RAM: begin
                        if ({1'b0, a[15:0]} < 17'(RAM_BYTES)) begin
                            sel[spad_pkg::TGT_RAM] = 1'b1; // RULE8 RULE20
                        end else begin
                            sel[spad_pkg::TGT_ERR] = 1'b1; // RULE8
                        end
                        loc = {32'h0, a[15:0]};
                    end
                    spad_pkg::PK_PERI: begin
                        sel[spad_pkg::TGT_PERI] = 1'b1; // RULE5 RULE6 RULE7 RULE21
                        loc = {16'h0, a[31:0]};
                        // Secure page seen nonsecure: read zero, write dropped
                        wirz = req.nonsecure_attribute && (pg == 16'(SEC_PERI)); // RULE22
                    end
                    spad_pkg::PK_SMEM: begin
                        sel[spad_pkg::TGT_SMEM] = 1'b1; // RULE5 RULE6
                        loc = {16'h0, a[31:0]};
                    end
                    spad_pkg::PK_MIO: begin
                        sel[spad_pkg::TGT_MIO] = 1'b1; // RULE9
                        loc = a - spad_pkg::MIO32_BASE;
                    end
                    default: begin
                        sel[spad_pkg::TGT_ERR] = 1'b1; // RULE5 RULE23
                    end
                endcase
            end
        end else begin
            // Find the map level: highest nibble above bit 31 that is set
            for (int i = 0; i < 4; i++) begin
                if (a[32 + 4*i +: 4] != 4'h0) begin
                    lvl = i;
                    nib = a[32 + 4*i +: 4];
                end
            end
            // Repeating sixteenths: 1-3 reserved, 4-7 mapped I/O, lower half of 8 hole if enabled, rest of 8 and 9-15 DRAM
            if (nib < 4'h4) begin
                sel[spad_pkg::TGT_ERR] = 1'b1; // RULE12 RULE15 RULE17 RULE18
            end else if (nib < 4'h8) begin
                sel[spad_pkg::TGT_MIO] = 1'b1; // RULE13 RULE15 RULE17 RULE18
            end else if (nib == 4'h8 && a[31 + 4*lvl] == 1'b0 && HOLE_EN) begin
                sel[spad_pkg::TGT_ERR] = 1'b1; // RULE14 RULE16 RULE25
            end else begin
                sel[spad_pkg::TGT_DRAM] = 1'b1; // RULE14 RULE16 RULE17 RULE18
                // One subtraction in the high bits; the hole keeps partitions apart
                loc = a - (48'h8 << (32 + 4*lvl)); // RULE24
            end
        end
        rsp_d.sel        = req.valid ? sel : '0; // RULE26
        rsp_d.local_addr = loc;
        rsp_d.page       = pg[spad_pkg::PAGE_W-1:0];
        rsp_d.write_ignore_read_zero = req.valid && wirz;
        rsp_d.valid      = req.valid;
    end

    // ------------------------------------------------------------
    // Registered answer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    assign rsp = rsp_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    boot_rom_low_a: assert property (@(posedge clk) disable iff (!rstn) // RULE1
        req.valid && req.addr[47:16] == 32'h0 |=> rsp.sel == 7'h01)
        else $error("Low boot window not ROM");
    boot_hivec_a: assert property (@(posedge clk) disable iff (!rstn) // RULE2
        req.valid && req.addr[47:16] == 32'h0000_FFFF |=> rsp.sel == 7'h01)
        else $error("High vector not ROM");
    hivec_fixed_a: assert property (@(posedge clk) disable iff (!rstn) // RULE3
        req.valid && req.addr[47:16] == 32'h0000_FFFF
        |=> rsp.local_addr == $past(req.addr) - 48'h0000_FFFF_0000)
        else $error("High vector not at fixed ROM offset");
    ram_hit_a: assert property (@(posedge clk) disable iff (!rstn) // RULE8
        req.valid && req.addr[47:16] == 32'(RAM_PAGE) && {1'b0, req.addr[15:0]} < 17'(RAM_BYTES)
        |=> rsp.sel == 7'h02)
        else $error("Populated RAM not selected");
    ram_gap_a: assert property (@(posedge clk) disable iff (!rstn) // RULE8
        req.valid && req.addr[47:16] == 32'(RAM_PAGE) && {1'b0, req.addr[15:0]} >= 17'(RAM_BYTES)
        |=> rsp.sel == 7'h40)
        else $error("RAM gap not error");
    peri_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE7
        req.valid && req.addr[47:32] == 16'h0 && req.addr[31:16] >= 16'(PERI_FIRST)
        && req.addr[31:16] <= 16'(PERI_LAST) |=> rsp.sel == 7'h04)
        else $error("Peripheral page miss");
    smem_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE6
        req.valid && req.addr[47:32] == 16'h0 && req.addr[31:16] >= 16'(SMEM_FIRST)
        && req.addr[31:16] <= 16'(SMEM_LAST) |=> rsp.sel == 7'h08)
        else $error("Static memory page miss");
    mio32_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE9
        req.valid && req.addr[47:30] == 18'h1 |=> rsp.sel == 7'h10)
        else $error("Mapped I/O miss");
    dram32_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE10
        req.valid && req.addr[47:31] == 17'h1 && req.addr[31:16] != 16'hFFFF
        |=> rsp.sel == 7'h20 && rsp.local_addr[47:31] == 17'h0)
        else $error("Low DRAM miss");
    onehot_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE26
        rsp.valid |-> $onehot(rsp.sel))
        else $error("Select not one-hot");
    idle_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // RULE26
        !req.valid |=> rsp.sel == 7'h00 && !rsp.valid)
        else $error("Select without request");
    wirz_nonsec_a: assert property (@(posedge clk) disable iff (!rstn) // RULE22
        req.valid && req.nonsecure_attribute && req.addr[47:16] == 32'(SEC_PERI)
        |=> rsp.write_ignore_read_zero && rsp.sel == 7'h04)
        else $error("Nonsecure access to secure page not read-zero");
    wirz_sec_clear_a: assert property (@(posedge clk) disable iff (!rstn) // RULE21
        req.valid && !req.nonsecure_attribute |=> !rsp.write_ignore_read_zero)
        else $error("Secure access flagged read-zero");
    wirz_only_peri_a: assert property (@(posedge clk) disable iff (!rstn) // RULE22
        rsp.write_ignore_read_zero |-> rsp.sel[2] && !rsp.sel[6])
        else $error("Read-zero outside peripheral");

    // ------------------------------------------------------------
    // Assertions on the wider maps
    // ------------------------------------------------------------
    beyond_map_a: assert property (@(posedge clk) disable iff (!rstn) // RULE23
        req.valid && (req.addr >> MAP_W) != 48'h0 |=> rsp.sel == 7'h40)
        else $error("Address beyond map not error");
    reserved_err_a: assert property (@(posedge clk) disable iff (!rstn) // RULE12
        req.valid && req.addr[47:34] == 14'h0 && req.addr[33:32] != 2'h0
        |=> rsp.sel == 7'h40)
        else $error("Reserved space not error");
    mio36_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE13
        MAP_W >= 36 && req.valid && req.addr[47:34] == 14'h1 |=> rsp.sel == 7'h10)
        else $error("Mapped I/O miss in 36-bit map");
    hole36_err_a: assert property (@(posedge clk) disable iff (!rstn) // RULE14
        MAP_W >= 36 && req.valid && req.addr[47:31] == 17'h10
        |=> rsp.sel == (HOLE_EN ? 7'h40 : 7'h20))
        else $error("Hole or DRAM miss in 36-bit map");
    dram36_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE24
        MAP_W >= 36 && req.valid && req.addr[47:35] == 13'h1 && req.addr[34:31] != 4'h0
        |=> rsp.sel == 7'h20 && rsp.local_addr == $past(req.addr) - 48'h8_0000_0000)
        else $error("DRAM miss in 36-bit map");
    resv40_err_a: assert property (@(posedge clk) disable iff (!rstn) // RULE15
        MAP_W >= 40 && req.valid && req.addr[47:38] == 10'h0 && req.addr[37:36] != 2'h0
        |=> rsp.sel == 7'h40)
        else $error("Reserved space not error in 40-bit map");
    mio40_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE15
        MAP_W >= 40 && req.valid && req.addr[47:38] == 10'h1 |=> rsp.sel == 7'h10)
        else $error("Mapped I/O miss in 40-bit map");
    hole40_err_a: assert property (@(posedge clk) disable iff (!rstn) // RULE16
        MAP_W >= 40 && req.valid && req.addr[47:35] == 13'h10
        |=> rsp.sel == (HOLE_EN ? 7'h40 : 7'h20))
        else $error("Hole or DRAM miss in 40-bit map");
    dram40_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE16
        MAP_W >= 40 && req.valid && req.addr[47:39] == 9'h1 && req.addr[38:35] != 4'h0
        |=> rsp.sel == 7'h20 && rsp.local_addr == $past(req.addr) - 48'h80_0000_0000)
        else $error("DRAM miss in 40-bit map");
    mio44_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE17
        MAP_W >= 44 && req.valid && req.addr[47:42] == 6'h1 |=> rsp.sel == 7'h10)
        else $error("Mapped I/O miss in 44-bit map");
    dram44_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE17
        MAP_W >= 44 && req.valid && req.addr[47:43] == 5'h1 && req.addr[42:39] != 4'h0
        |=> rsp.sel == 7'h20 && rsp.local_addr == $past(req.addr) - 48'h800_0000_0000)
        else $error("DRAM miss in 44-bit map");
    resv48_err_a: assert property (@(posedge clk) disable iff (!rstn) // RULE18
        MAP_W >= 48 && req.valid && req.addr[47:46] == 2'h0 && req.addr[45:44] != 2'h0
        |=> rsp.sel == 7'h40)
        else $error("Reserved space not error in 48-bit map");
    mio48_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE18
        MAP_W >= 48 && req.valid && req.addr[47:46] == 2'h1 |=> rsp.sel == 7'h10)
        else $error("Mapped I/O miss in 48-bit map");
    hole48_err_a: assert property (@(posedge clk) disable iff (!rstn) // RULE25
        MAP_W >= 48 && HOLE_EN && req.valid && req.addr[47:43] == 5'h10 |=> rsp.sel == 7'h40)
        else $error("Hole not error in 48-bit map");
    dram48_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RULE18
        MAP_W >= 48 && req.valid && req.addr[47] && req.addr[46:43] != 4'h0
        |=> rsp.sel == 7'h20 && rsp.local_addr == $past(req.addr) - 48'h8000_0000_0000)
        else $error("DRAM miss in 48-bit map");

endmodule

// File: bench/spad_master.sv
`timescale 1ns/10ps
// ----------------------------------------
// Request side model
// ----------------------------------------
module spad_master (
    input  wire logic           clk,
    output spad_pkg::spad_req_t req
);
    initial req = '0;
    // Called at a rising edge; a released address is inverted, never left stale
    task automatic put(input logic [47:0] a, input logic ns, input logic v);
        req.addr                <= v ? a : ~req.addr;
        req.nonsecure_attribute <= ns;
        req.write               <= ~ns;
        req.valid               <= v;
    endtask
endmodule

// File: bench/test_soc_physical_address_decoder.sv
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_soc_physical_address_decoder;
    logic                clk;
    logic                rstn;
    int                  fails;
    int                  num_checks;
    spad_pkg::spad_req_t req;
    spad_pkg::spad_rsp_t rsp;
    spad_pkg::spad_rsp_t rsp_n;

    initial clk = 1'b0;
    always #2 clk = ~clk;

    spad_master i_master (.clk(clk), .req(req));
    spad_decoder #(.MAP_W(48), .HOLE_EN(1'b1)) i_dut (
        .clk(clk), .rstn(rstn), .req(req), .rsp(rsp));
    // Narrow map without holes, to see the nesting
    spad_decoder #(.MAP_W(36), .HOLE_EN(1'b0)) i_dut_narrow (
        .clk(clk), .rstn(rstn), .req(req), .rsp(rsp_n));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic report_and_stop();
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic probe(input logic [47:0] a, input logic ns, input int t, input int tn,
                         input logic wz, input logic [47:0] la);
        @(posedge clk);
        i_master.put(a, ns, 1'b1);
        @(posedge clk);
        i_master.put(a, ns, 1'b0);
        #1;
        `CHK(rsp.valid, 1'b1)
        `CHK(rsp.sel, 7'h01 << t)
        `CHK(rsp_n.sel, 7'h01 << tn)
        `CHK(rsp.write_ignore_read_zero, wz)
        `CHK(rsp.page, a[spad_pkg::PAGE_SHIFT +: spad_pkg::PAGE_W])
        if (t == spad_pkg::TGT_DRAM) `CHK(rsp.local_addr, la)
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Low map, one request every cycle
    task automatic low_map_b2b();
        logic [47:0] a [16] = '{48'h0, 48'hFFFF, 48'hFFFF_0000, 48'h1_0000, 48'h1_7FFF,
            48'h1_8000, 48'h2_0000, 48'h10_0000, 48'hFF_FFFF, 48'h100_0000, 48'h1FF_FFFF,
            48'h200_0000, 48'h3FFF_FFFF, 48'h4000_0000, 48'h7FFF_FFFF, 48'h8000_0000};
        int t [16] = '{0, 0, 0, 1, 1, 6, 6, 2, 2, 3, 3, 6, 6, 4, 4, 5};
        for (int i = 0; i <= 16; i++) begin
            @(posedge clk);
            i_master.put(a[i % 16], 1'b0, i < 16);
            if (i > 0) begin
                #1;
                `CHK(rsp.sel, 7'h01 << t[i-1])
                `CHK(rsp_n.sel, 7'h01 << t[i-1])
            end
        end
    endtask

    task automatic high_maps();
        logic [47:0] a [19] = '{48'h8000_0000, 48'hFFFE_FFFF, 48'h1_0000_0000,
            48'h4_0000_0000, 48'h8_0000_0000, 48'h8_7FFF_FFFF, 48'h8_8000_0000,
            48'hF_FFFF_FFFF, 48'h10_0000_0000, 48'h40_0000_0000, 48'h80_0000_0000,
            48'h88_0000_0000, 48'h100_0000_0000, 48'h400_0000_0000, 48'h880_0000_0000,
            48'h1000_0000_0000, 48'h4000_0000_0000, 48'h8000_0000_0000, 48'h8800_0000_0000};
        logic [47:0] la [19] = '{48'h0, 48'h7FFE_FFFF, 48'h0, 48'h0, 48'h0, 48'h0,
            48'h8000_0000, 48'h7_FFFF_FFFF, 48'h0, 48'h0, 48'h0, 48'h8_0000_0000, 48'h0,
            48'h0, 48'h80_0000_0000, 48'h0, 48'h0, 48'h0, 48'h800_0000_0000};
        int t [19] = '{5, 5, 6, 4, 6, 6, 5, 5, 6, 4, 6, 5, 6, 4, 5, 6, 4, 6, 5};
        int tn [19] = '{5, 5, 6, 4, 5, 5, 5, 5, 6, 6, 6, 6, 6, 6, 6, 6, 6, 6, 6};
        for (int i = 0; i < 19; i++) begin
            probe(a[i], 1'b0, t[i], tn[i], 1'b0, la[i]);
        end
    endtask

    // Secure page seen from both spaces, then an idle cycle
    task automatic security();
        probe(48'h10_0000, 1'b1, 2, 2, 1'b1, 48'h0);
        probe(48'h10_0000, 1'b0, 2, 2, 1'b0, 48'h0);
        probe(48'h11_0000, 1'b1, 2, 2, 1'b0, 48'h0);
        probe(48'h8000_0000, 1'b1, 5, 5, 1'b0, 48'h0);
        @(posedge clk);
        #1;
        `CHK(rsp.valid, 1'b0)
        `CHK(rsp.sel, 7'h00)
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        fails = 0;
        num_checks = 0;
        rstn = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        `CHK(rsp, spad_pkg::spad_rsp_t'(0))
        @(posedge clk);
        rstn <= 1'b1;
        low_map_b2b();
        high_maps();
        security();
        report_and_stop();
    end

    // Far above the under one hundred cycles the scenarios need
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        report_and_stop();
    end
endmodule
